// *** src/lfwsr_top.sv ***
// register bank: fault response, shared fault timer, watchdog tap, clear-on-read status
// assumes xfer_done_i pulses one cycle at the end of each valid transfer, with
// xfer_write_i, xfer_addr_i and xfer_wdata_i valid in that cycle; rdata_o is
// shifted out during the following transfer
`timescale 1ns/1ps
module lfwsr_top #(
  parameter int unsigned FAULT_BASE_CYCLES = lfwsr_pkg::FAULT_BASE_CYCLES,
  parameter int unsigned WDG_TICK_CYCLES = lfwsr_pkg::WDG_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic xfer_done_i,
  input wire logic xfer_write_i,
  input wire logic [7:0] xfer_addr_i,
  input wire logic [7:0] xfer_wdata_i,
  input wire logic [1:0] ch_thermal_i,
  input wire logic [1:0] ch_hs_limit_i,
  input wire logic [1:0] ch_ls_limit_i,
  input wire logic [1:0] ch_short_i,
  input wire logic [1:0] ch_comp_ov_i,
  input wire logic [1:0] ch_boot_uv_i,
  input wire logic [1:0] ch_toffmin_i,
  output logic [7:0] rdata_o,
  output logic [1:0] ch_run_o,
  output logic limp_home_o
);
  logic [7:0] sys_cfg_reg, sys_cfg_next;
  logic [7:0] fault_cfg_reg, fault_cfg_next;
  logic [7:0] tap_reg, tap_next;
  logic [7:0] fault_stat_reg, fault_stat_next;
  logic [7:0] boot_stat_reg, boot_stat_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] pend_addr_reg, pend_addr_next;
  logic pend_valid_reg, pend_valid_next;
  logic [1:0] exp_cnt_reg, exp_cnt_next;
  lfwsr_pkg::lfwsr_ft_t ft_cnt_reg, ft_cnt_next;
  logic ft_active_reg, ft_active_next;
  logic [1:0] hold_reg, hold_next;
  logic [1:0] run_reg, run_next;
  logic [1:0] latch_trip, auto_ilim;
  logic [7:0] live1, live2;
  logic ft_start, ft_expire, wdg_expire;
  lfwsr_pkg::lfwsr_ft_t ft_limit;

  // mask of bits reported by the previous read, applied as the response transfer ends
  function automatic logic [7:0] clear_for(input logic [7:0] off);
    if (xfer_done_i && pend_valid_reg && pend_addr_reg == off) begin
      return rdata_reg; // RQ10
    end
    return lfwsr_pkg::BYTE_ZERO;
  endfunction

  for (genvar c = 0; c < lfwsr_pkg::NUM_CH; c++) begin : g_ch
    logic ts_sel, hs_sel, ls_sel;
    assign ts_sel = fault_cfg_reg[c * lfwsr_pkg::FCFG_STRIDE + lfwsr_pkg::FCFG_TS];
    assign hs_sel = fault_cfg_reg[c * lfwsr_pkg::FCFG_STRIDE + lfwsr_pkg::FCFG_HS];
    assign ls_sel = fault_cfg_reg[c * lfwsr_pkg::FCFG_STRIDE + lfwsr_pkg::FCFG_LS];
    assign latch_trip[c] = (ch_thermal_i[c] & ts_sel) // RQ2
                         | (ch_hs_limit_i[c] & hs_sel) // RQ3
                         | (ch_ls_limit_i[c] & ls_sel); // RQ4
    assign auto_ilim[c] = (ch_hs_limit_i[c] & ~hs_sel) | (ch_ls_limit_i[c] & ~ls_sel);
    // auto-restart on limit: held off until the shared timer runs out
    assign hold_next[c] = auto_ilim[c] | (hold_reg[c] & ~ft_expire); // RQ3 RQ4
    // thermal auto-restart simply follows the sensor's own hysteresis
    assign run_next[c] = sys_cfg_next[c * lfwsr_pkg::CH_EN_STRIDE]
                       & ~ch_thermal_i[c] & ~hold_next[c]; // RQ2
    assign live1[c * lfwsr_pkg::S1_STRIDE + lfwsr_pkg::S1_LS] = ch_ls_limit_i[c]; // RQ12
    assign live1[c * lfwsr_pkg::S1_STRIDE + lfwsr_pkg::S1_HS] = ch_hs_limit_i[c]; // RQ12
    assign live1[c * lfwsr_pkg::S1_STRIDE + lfwsr_pkg::S1_SHORT] = ch_short_i[c]; // RQ12
    assign live1[c * lfwsr_pkg::S1_STRIDE + lfwsr_pkg::S1_COMP_OV] = ch_comp_ov_i[c]; // RQ12
    assign live2[c * lfwsr_pkg::S2_STRIDE + lfwsr_pkg::S2_THERMAL] = ch_thermal_i[c];
    assign live2[c * lfwsr_pkg::S2_STRIDE + lfwsr_pkg::S2_BOOT_UV] = ch_boot_uv_i[c];
    assign live2[c * lfwsr_pkg::S2_STRIDE + lfwsr_pkg::S2_TOFFMIN] = ch_toffmin_i[c];
  end
  assign live2[7:6] = 2'b00;

  // shared fault timer
  assign ft_start = |auto_ilim;
  assign ft_limit = lfwsr_pkg::lfwsr_ft_t'(FAULT_BASE_CYCLES
                                           << fault_cfg_reg[lfwsr_pkg::FT_LSB +: 2]); // RQ1
  assign ft_expire = ft_active_reg & ~ft_start & (ft_cnt_reg >= ft_limit - lfwsr_pkg::FT_ONE); // RQ1

  always_comb begin
    ft_cnt_next = ft_cnt_reg;
    ft_active_next = ft_active_reg;
    if (ft_start) begin
      // a persisting limit keeps restarting the timer
      ft_cnt_next = lfwsr_pkg::FT_ZERO;
      ft_active_next = 1'b1;
    end else if (ft_expire) begin
      ft_cnt_next = lfwsr_pkg::FT_ZERO;
      ft_active_next = 1'b0;
    end else if (ft_active_reg) begin
      ft_cnt_next = ft_cnt_reg + lfwsr_pkg::FT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ft_cnt_reg <= lfwsr_pkg::FT_ZERO;
      ft_active_reg <= 1'b0;
      hold_reg <= 2'b00;
      run_reg <= 2'b00;
    end else begin
      ft_cnt_reg <= ft_cnt_next;
      ft_active_reg <= ft_active_next;
      hold_reg <= hold_next;
      run_reg <= run_next;
    end
  end

  lfwsr_watchdog #(
    .TICK_CYCLES(WDG_TICK_CYCLES)
  ) u_wdg (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(sys_cfg_reg[lfwsr_pkg::WDG_EN_POS]), // RQ13
    .kick_i(xfer_done_i), // RQ15
    .tap_sel_i(tap_reg[3:0]),
    .expire_o(wdg_expire)
  );

  // register file, read response and clear-on-read
  always_comb begin
    logic [7:0] clr1, clr2, clr3, s3, rd_val;
    logic [1:0] exp_base;
    clr1 = clear_for(lfwsr_pkg::REG_FAULT_STAT);
    clr2 = clear_for(lfwsr_pkg::REG_BOOT_STAT);
    clr3 = clear_for(lfwsr_pkg::REG_SYS_STAT);
    s3 = lfwsr_pkg::BYTE_ZERO;
    s3[lfwsr_pkg::S3_CNT_LSB +: 2] = exp_cnt_reg;
    rd_val = lfwsr_pkg::BYTE_ZERO;
    sys_cfg_next = sys_cfg_reg;
    fault_cfg_next = fault_cfg_reg;
    tap_next = tap_reg;
    rdata_next = rdata_reg;
    pend_addr_next = pend_addr_reg;
    pend_valid_next = pend_valid_reg;
    // live condition re-sets a bit, so set wins over clear
    fault_stat_next = live1 | (fault_stat_reg & ~clr1); // RQ9 RQ11
    boot_stat_next = (live2 | (boot_stat_reg & ~clr2)) & lfwsr_pkg::BOOT_STAT_MASK; // RQ9
    exp_base = (clr3[lfwsr_pkg::S3_CNT_LSB +: 2] != lfwsr_pkg::EXP_ZERO) ? lfwsr_pkg::EXP_ZERO
                                                                        : exp_cnt_reg;
    exp_cnt_next = exp_base;
    if (wdg_expire && exp_base != lfwsr_pkg::EXP_MAX) begin
      exp_cnt_next = exp_base + lfwsr_pkg::EXP_ONE; // RQ14
    end
    case (xfer_addr_i)
      lfwsr_pkg::REG_SYS_CFG: rd_val = sys_cfg_reg;
      lfwsr_pkg::REG_FAULT_CFG: rd_val = fault_cfg_reg;
      lfwsr_pkg::REG_TAP: rd_val = tap_reg;
      lfwsr_pkg::REG_FAULT_STAT: rd_val = fault_stat_reg;
      lfwsr_pkg::REG_BOOT_STAT: rd_val = boot_stat_reg;
      lfwsr_pkg::REG_SYS_STAT: rd_val = s3;
      default: rd_val = lfwsr_pkg::BYTE_ZERO;
    endcase
    if (xfer_done_i) begin
      if (xfer_write_i) begin
        pend_valid_next = 1'b0;
        case (xfer_addr_i)
          lfwsr_pkg::REG_SYS_CFG: sys_cfg_next = xfer_wdata_i & lfwsr_pkg::SYS_CFG_WR_MASK; // RQ5
          lfwsr_pkg::REG_FAULT_CFG: fault_cfg_next = xfer_wdata_i;
          lfwsr_pkg::REG_TAP: tap_next = xfer_wdata_i & lfwsr_pkg::TAP_MASK; // RQ7 RQ8
          default: ;
        endcase
      end else begin
        rdata_next = rd_val;
        pend_valid_next = 1'b1;
        pend_addr_next = xfer_addr_i;
      end
    end
    if (wdg_expire && exp_base == lfwsr_pkg::EXP_LIMP_PREV) begin
      sys_cfg_next[lfwsr_pkg::LIMP_POS] = 1'b1; // RQ14
    end
    for (int c = 0; c < lfwsr_pkg::NUM_CH; c++) begin
      // a latching fault beats a host enable in the same cycle
      if (latch_trip[c]) begin
        sys_cfg_next[c * lfwsr_pkg::CH_EN_STRIDE] = 1'b0; // RQ2 RQ3 RQ4 RQ5
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sys_cfg_reg <= lfwsr_pkg::SYS_CFG_RST; // RQ13
      fault_cfg_reg <= lfwsr_pkg::FAULT_CFG_RST;
      tap_reg <= lfwsr_pkg::TAP_RST; // RQ6 RQ8
      fault_stat_reg <= lfwsr_pkg::BYTE_ZERO;
      boot_stat_reg <= lfwsr_pkg::BYTE_ZERO;
      rdata_reg <= lfwsr_pkg::BYTE_ZERO;
      pend_addr_reg <= lfwsr_pkg::BYTE_ZERO;
      pend_valid_reg <= 1'b0;
      exp_cnt_reg <= lfwsr_pkg::EXP_ZERO;
    end else begin
      sys_cfg_reg <= sys_cfg_next;
      fault_cfg_reg <= fault_cfg_next;
      tap_reg <= tap_next;
      fault_stat_reg <= fault_stat_next;
      boot_stat_reg <= boot_stat_next;
      rdata_reg <= rdata_next;
      pend_addr_reg <= pend_addr_next;
      pend_valid_reg <= pend_valid_next;
      exp_cnt_reg <= exp_cnt_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign ch_run_o = run_reg;
  assign limp_home_o = sys_cfg_reg[lfwsr_pkg::LIMP_POS];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  tap_reset_val_a: assert property ($past(!reset_n_i) |-> tap_reg == lfwsr_pkg::TAP_RST // RQ8
                                    && sys_cfg_reg[lfwsr_pkg::WDG_EN_POS]) // RQ13
    else $error("tap select or watchdog enable wrong after reset");
  latch_off_a: assert property (latch_trip[0] |=> !sys_cfg_reg[0] && !ch_run_o[0]) // RQ5
    else $error("latching fault left channel 1 enabled");
  thermal_auto_a: assert property (ch_thermal_i[0] && !latch_trip[0] && sys_cfg_reg[0]
                                   && !(xfer_done_i && xfer_write_i) |=> sys_cfg_reg[0]) // RQ2
    else $error("auto-restart thermal fault cleared enable");
  limit_hold_a: assert property (auto_ilim[0]
                                 |=> !ch_run_o[0] && hold_reg[0] && ft_active_reg) // RQ3
    else $error("auto-restart limit did not hold channel");
  // a limit code lowered mid-run is allowed one cycle to expire the timer
  timer_bound_a: assert property (ft_active_reg && $stable(fault_cfg_reg[lfwsr_pkg::FT_LSB +: 2])
                                  |-> ft_cnt_reg < ft_limit) // RQ1
    else $error("fault timer ran past its limit");
  timer_release_a: assert property (ft_expire && !auto_ilim[1] |=> !hold_reg[1]) // RQ4
    else $error("channel not released at timer expiry");
  status_map_a: assert property (ch_ls_limit_i[0] || ch_comp_ov_i[1]
                                 |=> (fault_stat_reg[3] || !$past(ch_ls_limit_i[0]))
                                 && (fault_stat_reg[4] || !$past(ch_comp_ov_i[1]))) // RQ12
    else $error("status bit positions wrong");
  status_sticky_a: assert property (live1 != 8'h00
                                    |=> (fault_stat_reg & $past(live1)) == $past(live1)) // RQ9
    else $error("live condition not held in status");
  cmd_no_clear_a: assert property (xfer_done_i && !pend_valid_reg
                                   |=> fault_stat_reg == ($past(fault_stat_reg) | $past(live1))) // RQ10
    else $error("status cleared by command transfer");
  resp_clear_a: assert property (xfer_done_i && pend_valid_reg
                                 && pend_addr_reg == lfwsr_pkg::REG_FAULT_STAT && live1 == 8'h00
                                 |=> (fault_stat_reg & $past(rdata_reg)) == 8'h00) // RQ9
    else $error("read response did not clear status");
  exp_sat_a: assert property (exp_cnt_reg == lfwsr_pkg::EXP_MAX && wdg_expire
                              && !(xfer_done_i && pend_valid_reg)
                              |=> exp_cnt_reg == lfwsr_pkg::EXP_MAX) // RQ14
    else $error("expiry count wrapped");
  limp_enter_a: assert property (wdg_expire && exp_cnt_reg == lfwsr_pkg::EXP_LIMP_PREV
                                 && !xfer_done_i |=> limp_home_o) // RQ14
    else $error("third expiry did not enter limp-home");
endmodule

// *** src/lfwsr_pkg.sv ***
// constants, field positions and small types for the led fault / watchdog / status register bank
// assumes a serial front end that decodes each transfer and gives one pulse at its end
//
// What this block does
// RQ1: one shared fault timer, 2-bit limit code: 3.6, 7.2, 14.4, 28.8 ms.
// RQ2: thermal select 0 restarts on hysteresis; 1 latches off, clearing enable bit.
// RQ3: high-side limit select 0 restarts after fault timer; 1 latches off, clears enable.
// RQ4: low-side limit select 0 restarts after fault timer; 1 latches off, clears enable.
// RQ5: latched-off channel stays off until host writes its enable bit high again.
// RQ6: watchdog uses 25-bit counter, timeout at selectable tap, default tap bit 24.
// RQ7: tap codes 0000 to 0111 select counter bits 16 to 23.
// RQ8: tap codes 1000 to 1111 select bit 24; field resets to 1000.
// RQ9: status read-only; read clears set bits whose condition is gone, others stay.
// RQ10: clearing happens at end of the response transfer, not the command transfer.
// RQ11: every status bit is active high.
// RQ12: first status register at 0x03 holds per-channel limit, short, overvoltage flags.
// RQ13: watchdog runs only while its enable bit is set; enable set after reset.
// RQ14: watchdog expiries counted in 2-bit saturating field; third expiry enters limp-home.
// RQ15: every valid host transfer restarts watchdog counter; host must talk often enough.
package lfwsr_pkg;
  localparam int NUM_CH = 2;
  localparam logic [7:0] REG_SYS_CFG = 8'h00;
  localparam logic [7:0] REG_FAULT_CFG = 8'h01;
  localparam logic [7:0] REG_TAP = 8'h02;
  localparam logic [7:0] REG_FAULT_STAT = 8'h03;
  localparam logic [7:0] REG_BOOT_STAT = 8'h04;
  localparam logic [7:0] REG_SYS_STAT = 8'h05;
  localparam logic [7:0] SYS_CFG_RST = 8'h10;
  localparam logic [7:0] SYS_CFG_WR_MASK = 8'h7F;
  localparam logic [7:0] FAULT_CFG_RST = 8'h00;
  localparam logic [7:0] TAP_RST = 8'h08;
  localparam logic [7:0] TAP_MASK = 8'h0F;
  localparam logic [7:0] BOOT_STAT_MASK = 8'h3F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // system config fields
  localparam int CH_EN_STRIDE = 2;
  localparam int WDG_EN_POS = 4;
  localparam int LIMP_POS = 5;
  // fault response config fields
  localparam int FCFG_STRIDE = 3;
  localparam int FCFG_LS = 0;
  localparam int FCFG_HS = 1;
  localparam int FCFG_TS = 2;
  localparam int FT_LSB = 6;
  // status fields
  localparam int S1_STRIDE = 4;
  localparam int S1_COMP_OV = 0;
  localparam int S1_SHORT = 1;
  localparam int S1_HS = 2;
  localparam int S1_LS = 3;
  localparam int S2_STRIDE = 3;
  localparam int S2_TOFFMIN = 0;
  localparam int S2_BOOT_UV = 1;
  localparam int S2_THERMAL = 2;
  localparam int S3_CNT_LSB = 4;
  localparam logic [1:0] EXP_ZERO = 2'h0;
  localparam logic [1:0] EXP_ONE = 2'h1;
  localparam logic [1:0] EXP_LIMP_PREV = 2'h2;
  localparam logic [1:0] EXP_MAX = 2'h3;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned FAULT_TIME_BASE_NS = 3600000;
  localparam int unsigned FAULT_BASE_CYCLES = FAULT_TIME_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned WDG_TICK_NS = 91;
  localparam int unsigned WDG_TICK_CYCLES = WDG_TICK_NS / CLK_PERIOD_NS;
  localparam int FT_W = 24;
  typedef logic [FT_W-1:0] lfwsr_ft_t;
  localparam lfwsr_ft_t FT_ONE = 24'h00_0001;
  localparam lfwsr_ft_t FT_ZERO = 24'h00_0000;
  // watchdog
  localparam int WDG_CNT_W = 25;
  typedef logic [WDG_CNT_W-1:0] lfwsr_wdg_t;
  typedef logic [4:0] lfwsr_bit_t;
  typedef logic [7:0] lfwsr_pre_t;
  localparam lfwsr_bit_t TAP_LOW_BIT = 5'h10;
  localparam lfwsr_bit_t TAP_MAX_BIT = 5'h18;
  localparam int TAP_WIDE_POS = 3;
endpackage

// *** src/lfwsr_watchdog.sv ***
// communication watchdog: prescaled 25-bit counter with selectable tap
// assumes kick_i pulses once per valid host transfer
`timescale 1ns/1ps
module lfwsr_watchdog #(
  parameter int unsigned TICK_CYCLES = lfwsr_pkg::WDG_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic kick_i,
  input wire logic [3:0] tap_sel_i,
  output logic expire_o
);
  lfwsr_pkg::lfwsr_wdg_t cnt_reg, cnt_next;
  lfwsr_pkg::lfwsr_pre_t pre_reg, pre_next;
  logic expire_reg, expire_next;
  lfwsr_pkg::lfwsr_bit_t tap;

  function automatic lfwsr_pkg::lfwsr_bit_t tap_bit(input logic [3:0] code);
    if (code[lfwsr_pkg::TAP_WIDE_POS]) begin
      return lfwsr_pkg::TAP_MAX_BIT; // RQ8
    end
    return lfwsr_pkg::TAP_LOW_BIT + {2'b00, code[2:0]}; // RQ7
  endfunction

  assign tap = tap_bit(tap_sel_i);

  always_comb begin
    cnt_next = cnt_reg;
    pre_next = pre_reg;
    expire_next = 1'b0;
    if (!enable_i || kick_i) begin
      // restart on every transfer; held at zero while disabled
      cnt_next = '0; // RQ13 RQ15
      pre_next = '0;
    end else if (cnt_reg[tap]) begin
      expire_next = 1'b1; // RQ6
      cnt_next = '0;
      pre_next = '0;
    end else if (pre_reg == lfwsr_pkg::lfwsr_pre_t'(TICK_CYCLES - 1)) begin
      pre_next = '0;
      cnt_next = cnt_reg + lfwsr_pkg::lfwsr_wdg_t'(1);
    end else begin
      pre_next = pre_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
      pre_reg <= '0;
      expire_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pre_reg <= pre_next;
      expire_reg <= expire_next;
    end
  end

  assign expire_o = expire_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  wdg_off_hold_a: assert property (!enable_i |=> cnt_reg == '0 && !expire_o) // RQ13
    else $error("watchdog counted while disabled");
  wdg_kick_a: assert property (kick_i |=> cnt_reg == '0 && !expire_o) // RQ15
    else $error("transfer did not restart watchdog");
  wdg_tap_hit_a: assert property (enable_i && !kick_i && cnt_reg[tap] |=> expire_o) // RQ6
    else $error("tap reached without expiry");
  wdg_tap_early_a: assert property (expire_o |-> $past(cnt_reg[tap])) // RQ7
    else $error("expiry without tap bit set");
endmodule

// *** tb/lfwsr_host_model.sv ***
// host-side model: issues decoded serial transfers to the register bank
// assumes the bank samples a transfer at the rising edge where xfer_done_o is high
`timescale 1ns/1ps
module lfwsr_host_model (
  input wire logic clk_i,
  output logic xfer_done_o,
  output logic xfer_write_o,
  output logic [7:0] xfer_addr_o,
  output logic [7:0] xfer_wdata_o
);
  initial begin
    xfer_done_o = 1'b0;
    xfer_write_o = 1'b0;
    xfer_addr_o = 8'h00;
    xfer_wdata_o = 8'h00;
  end

  // one transfer of either kind; each one also restarts the watchdog
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    xfer_done_o <= 1'b1;
    xfer_write_o <= wr;
    xfer_addr_o <= addr;
    xfer_wdata_o <= data;
    @(posedge clk_i);
    // released lines flip so a stale value never looks like a request
    xfer_done_o <= 1'b0;
    xfer_write_o <= ~wr;
    xfer_addr_o <= ~addr;
    xfer_wdata_o <= ~data;
  endtask
endmodule

// *** tb/lfwsr_top_bench.sv ***
// self-checking bench for the register bank, driven through the host model
// assumes shortened fault timer base and a watchdog tick of one cycle
`timescale 1ns/1ps
module lfwsr_top_bench;
  localparam int unsigned FT_BASE = 20;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic xfer_done, xfer_write;
  logic [7:0] xfer_addr, xfer_wdata, rdata;
  logic [1:0] thermal = 2'b00, hs = 2'b00, ls = 2'b00, shrt = 2'b00, cov = 2'b00;
  logic [1:0] buv = 2'b00, tmin = 2'b00, ch_run;
  logic limp;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  always #10 clk_i = ~clk_i;

  lfwsr_host_model i_host (
    .clk_i(clk_i),
    .xfer_done_o(xfer_done),
    .xfer_write_o(xfer_write),
    .xfer_addr_o(xfer_addr),
    .xfer_wdata_o(xfer_wdata)
  );

  lfwsr_top #(.FAULT_BASE_CYCLES(FT_BASE), .WDG_TICK_CYCLES(1)) i_dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .xfer_done_i(xfer_done),
    .xfer_write_i(xfer_write),
    .xfer_addr_i(xfer_addr),
    .xfer_wdata_i(xfer_wdata),
    .ch_thermal_i(thermal),
    .ch_hs_limit_i(hs),
    .ch_ls_limit_i(ls),
    .ch_short_i(shrt),
    .ch_comp_ov_i(cov),
    .ch_boot_uv_i(buv),
    .ch_toffmin_i(tmin),
    .rdata_o(rdata),
    .ch_run_o(ch_run),
    .limp_home_o(limp)
  );

  task automatic finish_test();
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_run(input logic [1:0] exp);
    #1;
    num_checks++;
    if (ch_run !== exp) begin
      fails++;
      $display("mismatch ch_run expected %b seen %b", exp, ch_run);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    i_host.xfer(1'b1, addr, data);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string what);
    i_host.xfer(1'b0, addr, 8'h00);
    #1;
    check_byte(what, exp, rdata);
  endtask

  // switch fault layout: ch2 in the upper nibble, ls/hs/short/comp_ov from msb down
  task automatic set_faults(input logic [7:0] f);
    @(posedge clk_i);
    ls <= {f[7], f[3]};
    hs <= {f[6], f[2]};
    shrt <= {f[5], f[1]};
    cov <= {f[4], f[0]};
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    logic [7:0] f;
    cyc(10);
    reset_n_i <= 1'b1;
    rd(8'h00, 8'h10, "sys_cfg reset");
    rd(8'h01, 8'h00, "fault_response_config reset");
    rd(8'h02, 8'h08, "watchdog_tap_select reset");
    rd(8'h03, 8'h00, "switch_fault_status reset");
    rd(8'h20, 8'h00, "unmapped read");
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h00, "status write ignored");
    for (int i = 0; i < 8; i++) begin
      f = 8'h01 << i;
      set_faults(f);
      cyc(2);
      set_faults(8'h00);
      rd(8'h03, f, "fault status flag");
      rd(8'h03, f, "fault status before response end");
      rd(8'h03, 8'h00, "fault status cleared");
    end
    set_faults(8'h02);
    cyc(2);
    rd(8'h03, 8'h02, "live flag");
    wr(8'h01, 8'h00);
    rd(8'h03, 8'h02, "live flag kept");
    rd(8'h03, 8'h02, "live flag kept again");
    set_faults(8'h00);
    rd(8'h03, 8'h02, "flag after drop");
    rd(8'h03, 8'h00, "flag cleared");
    tmin <= 2'b01;
    buv <= 2'b10;
    cyc(2);
    tmin <= 2'b00;
    buv <= 2'b00;
    rd(8'h04, 8'h11, "thermal_boot_status");
    // thermal auto restart, then latch-off and host re-enable
    wr(8'h00, 8'h15);
    cyc(2);
    check_run(2'b11);
    thermal <= 2'b01;
    cyc(2);
    check_run(2'b10);
    cyc(1);
    thermal <= 2'b00;
    cyc(2);
    check_run(2'b11);
    wr(8'h01, 8'h04);
    thermal <= 2'b01;
    cyc(2);
    thermal <= 2'b00;
    cyc(3);
    check_run(2'b10);
    rd(8'h00, 8'h14, "ch1 enable cleared");
    wr(8'h00, 8'h15);
    cyc(2);
    check_run(2'b11);
    // auto restart after the shared fault timer, every limit code
    wr(8'h00, 8'h14);
    for (int c = 0; c < 4; c++) begin
      wr(8'h01, 8'(c << 6));
      set_faults(8'h40);
      cyc(2);
      set_faults(8'h00);
      cyc((FT_BASE << c) - 4);
      check_run(2'b00);
      cyc(8);
      check_run(2'b10);
    end
    wr(8'h00, 8'h15);
    wr(8'h01, 8'h00);
    set_faults(8'h08);
    cyc(2);
    set_faults(8'h00);
    cyc(FT_BASE + 8);
    check_run(2'b11);
    wr(8'h01, 8'h08);
    set_faults(8'h80);
    cyc(2);
    set_faults(8'h00);
    cyc(2);
    rd(8'h00, 8'h11, "ch2 low side latch");
    check_run(2'b01);
    wr(8'h01, 8'h02);
    set_faults(8'h04);
    cyc(2);
    set_faults(8'h00);
    cyc(2);
    rd(8'h00, 8'h10, "ch1 high side latch");
    check_run(2'b00);
    // watchdog tap selection and a single expiry at counter bit 16
    wr(8'h02, 8'hF9);
    rd(8'h02, 8'h09, "tap readback");
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h00, "tap code zero");
    rd(8'h05, 8'h00, "no expiry yet");
    cyc(65600);
    rd(8'h05, 8'h10, "expiry count");
    rd(8'h05, 8'h10, "expiry count held");
    rd(8'h05, 8'h00, "expiry count cleared");
    check_byte("limp_home", 8'(limp), 8'h00);
    // host-set limp with the watchdog stopped, then back to normal
    wr(8'h00, 8'h20);
    cyc(1);
    check_byte("limp_home set", 8'(limp), 8'h01);
    wr(8'h00, 8'h10);
    cyc(1);
    check_byte("limp_home cleared", 8'(limp), 8'h00);
    finish_test();
  end
endmodule
